//--- rtl/pt8_pkg.sv
// package of the prescaled 8-bit timer: register map, fields, carriers
// Functional notes
// - counter counts up once per prescaled pulse and overflows after ff
// - each overflow reloads the counter from preload and counting goes on
// - a preload write while stopped is copied into the counter at once
// - a preload write while running waits in preload until next overflow
// - control bit 5 picks source: 0 system clock, 1 low-speed sub clock
// - control bit 4 runs the counter when set, stops it when clear
// - control bits 2..0 divide the source by 1 up to 128 in powers of two
// - control bits 7, 6 and 3 always read as zero
// - reading the count register returns the live counter, not preload
// - counting clock is inhibited during a count read or preload write
// - counter advances on the falling edge of the prescaled clock
// - overflow sets the request flag; interrupt only when enable bit set
// - overflow in power-down wakes the device whatever the enable, unless the request flag is already set
package pt8_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam logic [7:0] OFS_COUNT = 8'h00;
   localparam logic [7:0] OFS_CTRL = 8'h04;
   localparam logic [7:0] OFS_PRELOAD = 8'h08;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
   localparam int unsigned CTRL_SRC_BIT = 5;
   localparam int unsigned CTRL_RUN_BIT = 4;
   localparam int unsigned PSC_LSB = 0;
   localparam int unsigned PSC_W = 3;
   localparam int unsigned DIV_W = 7;
   localparam logic [7:0] CTRL_RW_MASK = 8'h37;
   localparam logic [7:0] COUNT_MAX = 8'hff;
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [7:0] RST_COUNT = 8'h00;
   localparam logic [7:0] RST_PRELOAD = 8'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [ADDR_W-1:0] araddr;
      logic rready;
   } pt8_axi_req_s;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } pt8_axi_rsp_s;

   typedef struct packed {
      logic meta;
      logic stable;
   } pt8_sync_s;

   typedef struct packed {
      logic sub_prev;
      logic [DIV_W-1:0] div;
   } pt8_psc_s;

   typedef struct packed {
      logic aw_rdy;
      logic w_rdy;
      logic aw_got;
      logic w_got;
      logic [ADDR_W-1:0] waddr;
      logic [7:0] wdata;
      logic wstrb0;
      logic wr_req;
      logic bvalid;
      logic [1:0] bresp;
      logic ar_rdy;
      logic rd_req;
      logic [ADDR_W-1:0] raddr;
      logic rvalid;
      logic [7:0] rdata;
      logic [1:0] rresp;
      logic [7:0] ctrl;
      logic [7:0] preload;
      logic [7:0] count;
      logic irq_stat;
      logic irq_mask;
      logic irq;
      logic ovf;
      logic wake;
   } pt8_top_s;

   function automatic logic pt8_is_mapped(input logic [ADDR_W-1:0] a);
      return (a == OFS_COUNT) || (a == OFS_CTRL) || (a == OFS_PRELOAD) ||
             (a == OFS_IRQ_STAT) || (a == OFS_IRQ_MASK);
   endfunction : pt8_is_mapped
endpackage : pt8_pkg

//--- rtl/pt8_sync2.sv
// two-flop synchroniser for the sub clock level
`timescale 1ns/1ps
`default_nettype none
module pt8_sync2
   import pt8_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic async_i,
   output logic sync_o
);
   pt8_sync_s s_q;
   pt8_sync_s s_d;

   always_comb begin
      s_d.meta = async_i;
      s_d.stable = s_q.meta;
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign sync_o = s_q.stable;
endmodule : pt8_sync2
`default_nettype wire

//--- rtl/pt8_prescaler.sv
// source select and power-of-two prescaler producing count ticks
`timescale 1ns/1ps
`default_nettype none
module pt8_prescaler
   import pt8_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic sub_clk_i,
   input wire logic src_sel_i,
   input wire logic run_i,
   input wire logic [PSC_W-1:0] psc_i,
   input wire logic inhibit_i,
   output logic tick_o
);
   pt8_psc_s s_q;
   pt8_psc_s s_d;
   logic sub_s;
   logic src_tick;
   logic step;
   logic [DIV_W-1:0] mask;

   pt8_sync2 u_sub_sync (
      .core_clk_i(core_clk_i),
      .resetn_i(resetn_i),
      .async_i(sub_clk_i),
      .sync_o(sub_s)
   );

   always_comb begin
      s_d = s_q;
      src_tick = src_sel_i ? (sub_s && !s_q.sub_prev) : 1'b1;
      // a source edge swallowed while inhibited is simply lost
      step = src_tick && run_i && !inhibit_i;
      mask = DIV_W'((8'h01 << psc_i) - 8'h01);
      // divided clock bit psc-1 falls when all lower bits are one
      tick_o = step && ((s_q.div & mask) == mask);
      s_d.sub_prev = sub_s;
      if (!run_i) begin
         s_d.div = '0;
      end else if (step) begin
         s_d.div = DIV_W'(s_q.div + 7'h01);
      end
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);

   AST_PSC_HELD: assert property (!run_i |=> s_q.div == '0)
      else $error("prescaler not held while stopped");
   AST_PSC_SYS_DIV1: assert property (
      run_i && !src_sel_i && !inhibit_i && psc_i == 3'h0 |-> tick_o)
      else $error("system clock divide by one missed a tick");
   AST_PSC_RATIO: assert property (
      tick_o && psc_i == 3'h7 && run_i |-> s_q.div == 7'h7f)
      else $error("divide by 128 ticked early");
endmodule : pt8_prescaler
`default_nettype wire

//--- rtl/pt8_timer.sv
// prescaled 8-bit timer with AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none
module pt8_timer
   import pt8_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire pt8_axi_req_s axi_req_i,
   output pt8_axi_rsp_s axi_rsp_o,
   input wire logic sub_clk_i,
   input wire logic powerdown_i,
   output logic ovf_pulse_o,
   output logic wake_o,
   output logic irq_o
);
   pt8_top_s s_q;
   pt8_top_s s_d;
   logic tick;
   logic run;
   logic wr_hit;
   logic wr_count;
   logic rd_count;
   logic [7:0] rd_mux;

   assign run = s_q.ctrl[CTRL_RUN_BIT];
   assign wr_hit = s_q.wr_req && s_q.wstrb0;
   assign wr_count = wr_hit && (s_q.waddr == OFS_COUNT);
   assign rd_count = s_q.rd_req && (s_q.raddr == OFS_COUNT);

   pt8_prescaler u_psc (
      .core_clk_i(core_clk_i),
      .resetn_i(resetn_i),
      .sub_clk_i(sub_clk_i),
      .src_sel_i(s_q.ctrl[CTRL_SRC_BIT]),
      .run_i(run),
      .psc_i(s_q.ctrl[PSC_LSB +: PSC_W]),
      .inhibit_i(wr_count || rd_count),
      .tick_o(tick)
   );

   always_comb begin
      case (s_q.raddr)
         OFS_COUNT: rd_mux = s_q.count;
         OFS_CTRL: rd_mux = s_q.ctrl & CTRL_RW_MASK;
         OFS_PRELOAD: rd_mux = s_q.preload;
         OFS_IRQ_STAT: rd_mux = {7'h00, s_q.irq_stat};
         OFS_IRQ_MASK: rd_mux = {7'h00, s_q.irq_mask};
         default: rd_mux = 8'h00;
      endcase
   end

   always_comb begin
      s_d = s_q;
      s_d.wr_req = 1'b0;
      s_d.rd_req = 1'b0;
      s_d.ovf = 1'b0;
      s_d.wake = 1'b0;

      // write address and data are taken in either order
      if (axi_req_i.awvalid && s_q.aw_rdy) begin
         s_d.aw_rdy = 1'b0;
         s_d.aw_got = 1'b1;
         s_d.waddr = axi_req_i.awaddr;
      end
      if (axi_req_i.wvalid && s_q.w_rdy) begin
         s_d.w_rdy = 1'b0;
         s_d.w_got = 1'b1;
         s_d.wdata = axi_req_i.wdata[7:0];
         s_d.wstrb0 = axi_req_i.wstrb[0];
      end
      if (s_q.aw_got && s_q.w_got) begin
         s_d.aw_got = 1'b0;
         s_d.w_got = 1'b0;
         s_d.wr_req = 1'b1;
         s_d.bvalid = 1'b1;
         s_d.bresp = pt8_is_mapped(s_q.waddr) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_q.bvalid && axi_req_i.bready) begin
         s_d.bvalid = 1'b0;
         s_d.aw_rdy = 1'b1;
         s_d.w_rdy = 1'b1;
      end

      // read data is sampled one cycle after the address is taken
      if (axi_req_i.arvalid && s_q.ar_rdy) begin
         s_d.ar_rdy = 1'b0;
         s_d.rd_req = 1'b1;
         s_d.raddr = axi_req_i.araddr;
      end
      if (s_q.rd_req) begin
         s_d.rvalid = 1'b1;
         s_d.rdata = rd_mux;
         s_d.rresp = pt8_is_mapped(s_q.raddr) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_q.rvalid && axi_req_i.rready) begin
         s_d.rvalid = 1'b0;
         s_d.ar_rdy = 1'b1;
      end

      // register writes; the count offset holds the preload on write
      if (wr_hit && s_q.waddr == OFS_CTRL) begin
         s_d.ctrl = s_q.wdata & CTRL_RW_MASK;
      end
      if (wr_count) begin
         s_d.preload = s_q.wdata;
         if (!run) begin
            s_d.count = s_q.wdata;
         end
      end
      if (wr_hit && s_q.waddr == OFS_IRQ_MASK) begin
         s_d.irq_mask = s_q.wdata[0];
      end
      if (wr_hit && s_q.waddr == OFS_IRQ_STAT && s_q.wdata[0]) begin
         s_d.irq_stat = 1'b0;
      end

      // tick never coincides with a count write: it is inhibited then
      if (tick && run) begin
         if (s_q.count == COUNT_MAX) begin
            s_d.count = s_q.preload;
            s_d.ovf = 1'b1;
         end else begin
            s_d.count = 8'(s_q.count + 8'h01);
         end
      end

      // overflow wins over a same-cycle clear of the request flag
      if (s_d.ovf) begin
         s_d.irq_stat = 1'b1;
         // an already pending flag masks the wake-up on purpose
         s_d.wake = powerdown_i && !s_q.irq_stat;
      end
      s_d.irq = s_q.irq_stat && s_q.irq_mask;
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s_q <= '0;
         s_q.aw_rdy <= 1'b1;
         s_q.w_rdy <= 1'b1;
         s_q.ar_rdy <= 1'b1;
         s_q.ctrl <= RST_CTRL;
         s_q.count <= RST_COUNT;
         s_q.preload <= RST_PRELOAD;
      end else begin
         s_q <= s_d;
      end
   end

   always_comb begin
      axi_rsp_o.awready = s_q.aw_rdy;
      axi_rsp_o.wready = s_q.w_rdy;
      axi_rsp_o.bvalid = s_q.bvalid;
      axi_rsp_o.bresp = s_q.bresp;
      axi_rsp_o.arready = s_q.ar_rdy;
      axi_rsp_o.rvalid = s_q.rvalid;
      axi_rsp_o.rdata = {24'h000000, s_q.rdata};
      axi_rsp_o.rresp = s_q.rresp;
   end

   assign ovf_pulse_o = s_q.ovf;
   assign wake_o = s_q.wake;
   assign irq_o = s_q.irq;

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);

   AST_COUNT_UP: assert property (
      tick && run && s_q.count != COUNT_MAX |=> s_q.count == $past(s_q.count) + 8'h01)
      else $error("counter did not step by one");
   AST_RELOAD: assert property (
      tick && run && s_q.count == COUNT_MAX |=> s_q.count == $past(s_q.preload) && ovf_pulse_o)
      else $error("overflow did not reload from preload");
   AST_STOPPED_LOAD: assert property (
      wr_count && !run |=> s_q.count == $past(s_q.wdata))
      else $error("stopped preload write not copied to counter");
   AST_RUNNING_LOAD: assert property (
      wr_count && run |=> s_q.count == $past(s_q.count) && s_q.preload == $past(s_q.wdata))
      else $error("running preload write disturbed the counter");
   AST_STOP_HOLD: assert property (
      !run && !wr_count |=> $stable(s_q.count))
      else $error("stopped counter moved");
   AST_CTRL_ZERO: assert property (
      s_q.rd_req && s_q.raddr == OFS_CTRL |=> axi_rsp_o.rvalid && axi_rsp_o.rdata[7:6] == 2'h0
         && axi_rsp_o.rdata[3] == 1'b0)
      else $error("unimplemented control bits read nonzero");
   AST_READ_LIVE: assert property (
      rd_count |=> axi_rsp_o.rdata[7:0] == $past(s_q.count) && $stable(s_q.count))
      else $error("count read not live or not inhibited");
   AST_IRQ_GATE: assert property (
      ovf_pulse_o && s_q.irq_mask && $stable(s_q.irq_mask) |=> irq_o)
      else $error("enabled overflow raised no interrupt");
   AST_IRQ_MASKED: assert property (
      !s_q.irq_mask |=> !irq_o)
      else $error("interrupt with enable clear");
   AST_WAKE: assert property (
      tick && run && s_q.count == COUNT_MAX && powerdown_i && !s_q.irq_stat |=> wake_o)
      else $error("power-down overflow gave no wake-up");
   AST_OVF_PULSE: assert property (
      ovf_pulse_o |-> $past(tick && run && s_q.count == COUNT_MAX))
      else $error("overflow pulse without overflow");
endmodule : pt8_timer
`default_nettype wire

//--- verif/pt8_intc_model.sv
// interrupt controller stand-in counting overflow requests and wake-ups
`timescale 1ns/1ps
`default_nettype none
module pt8_intc_model (
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic ovf_i,
   input wire logic wake_i,
   output logic [15:0] req_cnt_o,
   output logic [15:0] wake_cnt_o
);
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         req_cnt_o <= 16'h0000;
         wake_cnt_o <= 16'h0000;
      end else begin
         // one request per cycle the pulse is high, so a stretched pulse shows as extra requests
         if (ovf_i) begin
            req_cnt_o <= req_cnt_o + 16'h0001;
         end
         if (wake_i) begin
            wake_cnt_o <= wake_cnt_o + 16'h0001;
         end
      end
   end
endmodule : pt8_intc_model
`default_nettype wire

//--- verif/tb.sv
// self-checking bench of the prescaled 8-bit timer
`timescale 1ns/1ps
`default_nettype none
module tb;
   import pt8_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic sub_clk = 1'b0;
   logic pdown = 1'b0;
   pt8_axi_req_s req = '0;
   pt8_axi_rsp_s rsp;
   logic ovf;
   logic wake;
   logic irq;
   logic [15:0] req_cnt;
   logic [15:0] wake_cnt;
   int err_total = 0;
   int num_checks = 0;
   int cyc = 0;
   int sdiv = 0;
   int n;
   int c;
   logic [31:0] rv;
   logic [1:0] rr;

   pt8_timer i_dut (.core_clk_i(clk), .resetn_i(rstn), .axi_req_i(req), .axi_rsp_o(rsp),
      .sub_clk_i(sub_clk), .powerdown_i(pdown), .ovf_pulse_o(ovf), .wake_o(wake), .irq_o(irq));
   pt8_intc_model i_intc (.core_clk_i(clk), .resetn_i(rstn), .ovf_i(ovf), .wake_i(wake),
      .req_cnt_o(req_cnt), .wake_cnt_o(wake_cnt));

   initial begin
      forever #2.5 clk = ~clk;
   end

   // sub clock edges land on core edges so the sub-source period comes out exact
   always @(posedge clk) begin
      sdiv <= (sdiv == 9) ? 0 : sdiv + 1;
      if (sdiv == 9) begin
         sub_clk <= ~sub_clk;
      end
   end

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         wrap_up();
      end
   end

   task automatic wrap_up();
      $display("checks %0d, mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : wrap_up

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk

   // responses are sampled at the falling edge, i.e. as the next rising edge sees them
   // bready and rready stay high between calls: each call drives its ready high again and none drops it
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] st,
      output logic [1:0] r);
      pt8_axi_rsp_s s;
      req.awaddr <= a;
      req.wdata <= {24'h000000, d};
      req.wstrb <= st;
      req.awvalid <= 1'b1;
      req.wvalid <= 1'b1;
      req.bready <= 1'b1;
      do begin
         @(negedge clk);
         s = rsp;
         @(posedge clk);
         if (s.awready) begin
            req.awvalid <= 1'b0;
         end
         if (s.wready) begin
            req.wvalid <= 1'b0;
         end
      end while (!s.bvalid);
      r = s.bresp;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      pt8_axi_rsp_s s;
      req.araddr <= a;
      req.arvalid <= 1'b1;
      req.rready <= 1'b1;
      do begin
         @(negedge clk);
         s = rsp;
         @(posedge clk);
         if (s.arready) begin
            req.arvalid <= 1'b0;
         end
      end while (!s.rvalid);
      d = s.rdata;
      r = s.rresp;
   endtask : rd

   task automatic wchk(input logic [7:0] a, input logic [7:0] d);
      wr(a, d, 4'hf, rr);
      chk({30'h0, rr}, {30'h0, RESP_OKAY});
   endtask : wchk

   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      rd(a, rv, rr);
      chk({30'h0, rr}, {30'h0, RESP_OKAY});
      chk(rv, e);
   endtask : rchk

   // cycles between two overflow pulses
   task automatic per(output int p);
      do @(negedge clk); while (ovf !== 1'b1);
      p = 0;
      do begin
         @(negedge clk);
         p++;
      end while (ovf !== 1'b1);
      @(posedge clk);
   endtask : per

   initial begin
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      rchk(OFS_CTRL, 32'h0);
      rchk(OFS_COUNT, 32'h0);
      rd(8'h14, rv, rr);
      chk({30'h0, rr}, {30'h0, RESP_SLVERR});
      chk(rv, 32'h0);
      wr(8'h14, 8'hff, 4'hf, rr);
      chk({30'h0, rr}, {30'h0, RESP_SLVERR});
      wchk(OFS_CTRL, 8'hff);
      rchk(OFS_CTRL, 32'h37);
      wchk(OFS_CTRL, 8'h00);
      $display("test registers done");
      wchk(OFS_COUNT, 8'hfe);
      rchk(OFS_COUNT, 32'hfe);
      rchk(OFS_PRELOAD, 32'hfe);
      // low lane strobe clear: write dropped, still answered okay
      wr(OFS_COUNT, 8'h55, 4'he, rr);
      chk({30'h0, rr}, {30'h0, RESP_OKAY});
      rchk(OFS_COUNT, 32'hfe);
      wchk(OFS_IRQ_MASK, 8'h01);
      // the first interval after a ratio change may be mixed, so measure twice
      for (n = 0; n < 8; n++) begin
         wchk(OFS_CTRL, 8'h10 | n[7:0]);
         per(c);
         per(c);
         chk(c, 32'h2 << n);
      end
      rchk(OFS_IRQ_STAT, 32'h1);
      chk({31'h0, irq}, 32'h1);
      $display("test ratios done");
      per(c);
      wchk(OFS_COUNT, 8'h10);
      rchk(OFS_COUNT, 32'hfe);
      rchk(OFS_PRELOAD, 32'h10);
      // one overflow only: a whole lap from 10 at divide 128 would outrun the timeout
      n = int'(req_cnt);
      do @(negedge clk); while (ovf !== 1'b1);
      @(posedge clk);
      rchk(OFS_COUNT, 32'h10);
      chk({16'h0, req_cnt}, n + 1);
      wchk(OFS_CTRL, 8'h07);
      rchk(OFS_COUNT, 32'h10);
      repeat (300) @(posedge clk);
      rchk(OFS_COUNT, 32'h10);
      chk({16'h0, req_cnt}, n + 1);
      wchk(OFS_IRQ_STAT, 8'h01);
      rchk(OFS_IRQ_STAT, 32'h0);
      @(negedge clk);
      chk({31'h0, irq}, 32'h0);
      @(posedge clk);
      $display("test preload done");
      wchk(OFS_COUNT, 8'hfe);
      wchk(OFS_CTRL, 8'h30);
      per(c);
      per(c);
      chk(c, 32'h28);
      wchk(OFS_CTRL, 8'h00);
      wchk(OFS_IRQ_STAT, 8'h01);
      wchk(OFS_IRQ_MASK, 8'h00);
      wchk(OFS_COUNT, 8'hfe);
      pdown <= 1'b1;
      wchk(OFS_CTRL, 8'h10);
      per(c);
      per(c);
      // flag left set after the first wake stands for the flag set before halting
      chk({16'h0, wake_cnt}, 32'h1);
      chk({31'h0, irq}, 32'h0);
      pdown <= 1'b0;
      $display("test wake done");
      wrap_up();
   end
endmodule : tb
`default_nettype wire
